// [logic/gpc_map.vh]
`ifndef GPC_MAP_VH
`define GPC_MAP_VH

// ----------------------------------------
// I/O register offsets
// ----------------------------------------
`define GPC_ADDR_INPUT    8'h20
`define GPC_ADDR_DIR      8'h21
`define GPC_ADDR_DATA     8'h22
`define GPC_ADDR_FLAG     8'h30
`define GPC_ADDR_MCU      8'h31
`define GPC_ADDR_CTRL     8'h60
`define GPC_ADDR_MASK0    8'h6b
`define GPC_ADDR_MASK1    8'h6c
`define GPC_ADDR_MASK2    8'h6d

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define GPC_CTRL_EN0      0
`define GPC_CTRL_EN1      1
`define GPC_CTRL_EN2      2
`define GPC_FLAG_PCF0     0
`define GPC_MCU_PUD       4
`define GPC_RST_BYTE      8'h00
`define GPC_RST_CTRL      3'h0
`define GPC_RST_MASK1     7'h00
`define GPC_ZERO_BIT      1'h0

`endif

// [logic/gpc_sync.v]
`timescale 1ns/100ps
`include "gpc_map.vh"
// ----------------------------------------
// Pin input synchronizer
// ----------------------------------------
module gpc_sync (
	// Clock and reset
	input  wire       clk,
	input  wire       reset,
	// Pins and synchronized result
	input  wire [7:0] async_in,
	output reg  [7:0] sync_out
);

	// Holds what the pin showed while the clock was high
	reg [7:0] hold_low;

	// latch stage
	// Capture at the falling edge, same value a closing latch keeps
	always @(negedge clk) begin
		if (reset) begin
			hold_low <= `GPC_RST_BYTE;
		end else begin
			hold_low <= async_in;
		end
	end

	// register stage
	// Only this flop reads the first stage
	always @(posedge clk) begin
		if (reset) begin
			sync_out <= `GPC_RST_BYTE;
		end else begin
			sync_out <= hold_low;
		end
	end

endmodule

// [logic/gpc_port.v]
`timescale 1ns/100ps
`include "gpc_map.vh"
// ----------------------------------------
// General I/O port with pin-change masks
// ----------------------------------------
module gpc_port (
	// Clock and reset
	input  wire       clk,
	input  wire       reset,
	// I/O register access
	input  wire [7:0] io_addr,
	input  wire [7:0] io_wdata,
	input  wire       io_write,
	input  wire       io_read,
	input  wire       io_bit_set,
	input  wire       io_bit_clear,
	input  wire [2:0] io_bit_sel,
	output reg  [7:0] io_rdata,
	// Processor side
	input  wire       global_int_enable,
	input  wire       irq_ack_group0,
	output reg        irq_group0,
	// Synchronized levels of the other groups
	input  wire [6:0] group1_pins,
	input  wire [7:0] group2_pins,
	output reg        pc_req_group1,
	output reg        pc_req_group2,
	// Port pins
	input  wire [7:0] pin_in,
	output reg  [7:0] pin_out,
	output wire [7:0] pin_oe,
	output wire [7:0] pin_pullup
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// One-hot byte for a bit index
	function [7:0] gpc_onehot;
		input [2:0] sel;
		begin
			gpc_onehot = 8'h01 << sel;
		end
	endfunction

	// Effective new value of a read/write register
	function [7:0] gpc_merge;
		input [7:0] cur;
		input [7:0] wdata;
		input       wr;
		input       bset;
		input       bclr;
		input [2:0] sel;
		begin
			if (bset) begin
				gpc_merge = cur | gpc_onehot(sel);
			end else if (bclr) begin
				gpc_merge = cur & ~gpc_onehot(sel);
			end else if (wr) begin
				gpc_merge = wdata;
			end else begin
				gpc_merge = cur;
			end
		end
	endfunction

	// Value seen by a write-one-to-act location
	function [7:0] gpc_strobe;
		input [7:0] wdata;
		input       wr;
		input       bset;
		input [2:0] sel;
		begin
			if (bset) begin
				gpc_strobe = gpc_onehot(sel);
			end else if (wr) begin
				gpc_strobe = wdata;
			end else begin
				gpc_strobe = 8'h00;
			end
		end
	endfunction

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------

	reg  [7:0] port_direction_reg;
	reg  [7:0] port_output_data_reg;
	reg  [7:0] pin_change_mask_group0;
	reg  [6:0] pin_change_mask_group1;
	reg  [7:0] pin_change_mask_group2;
	reg  [2:0] pin_change_control_reg;
	reg        pin_change_flag_group0;
	reg        global_pullup_disable;
	reg  [7:0] port_prev;
	reg  [6:0] group1_prev;
	reg  [7:0] group2_prev;
	reg  [7:0] drive_en;
	reg  [7:0] pull_en;

	wire [7:0] port_input_pins_reg;
	wire       any_access;
	wire       sel_input;
	wire       sel_dir;
	wire       sel_data;
	wire       sel_flag;
	wire       sel_mcu;
	wire       sel_ctrl;
	wire       sel_mask0;
	wire       sel_mask1;
	wire       sel_mask2;

	reg  [7:0] next_direction;
	reg  [7:0] next_data;
	reg  [7:0] toggle_bits;
	reg  [7:0] flag_clear_bits;
	reg  [7:0] next_mcu;
	reg  [7:0] next_ctrl;
	reg  [7:0] next_mask0;
	reg  [7:0] next_mask1;
	reg  [7:0] next_mask2;
	reg  [7:0] next_rdata;
	reg        change_group0;
	reg        change_group1;
	reg        change_group2;
	reg        next_flag;

	// ----------------------------------------
	// Pin synchronizer
	// ----------------------------------------

	// pin readback path
	// Direction does not gate the path, so outputs read back too
	gpc_sync u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in (pin_in),
		.sync_out (port_input_pins_reg)
	);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------

	assign any_access = io_write | io_bit_set | io_bit_clear;
	assign sel_input  = (io_addr == `GPC_ADDR_INPUT);
	assign sel_dir    = (io_addr == `GPC_ADDR_DIR);
	assign sel_data   = (io_addr == `GPC_ADDR_DATA);
	assign sel_flag   = (io_addr == `GPC_ADDR_FLAG);
	assign sel_mcu    = (io_addr == `GPC_ADDR_MCU);
	assign sel_ctrl   = (io_addr == `GPC_ADDR_CTRL);
	assign sel_mask0  = (io_addr == `GPC_ADDR_MASK0);
	assign sel_mask1  = (io_addr == `GPC_ADDR_MASK1);
	assign sel_mask2  = (io_addr == `GPC_ADDR_MASK2);

	// Next values of the writable registers
	always @* begin
		next_direction  = port_direction_reg;
		next_mcu        = {3'h0, global_pullup_disable, 4'h0};
		next_ctrl       = {5'h00, pin_change_control_reg};
		next_mask0      = pin_change_mask_group0;
		next_mask1      = {1'b0, pin_change_mask_group1};
		next_mask2      = pin_change_mask_group2;
		toggle_bits     = 8'h00;
		flag_clear_bits = 8'h00;
		next_data       = port_output_data_reg;
		// single-bit operations
		// The merge keeps every unaddressed bit as it stands
		if (sel_dir) begin
			next_direction = gpc_merge(port_direction_reg, io_wdata,
				io_write, io_bit_set, io_bit_clear, io_bit_sel);
		end else if (sel_data) begin
			next_data = gpc_merge(port_output_data_reg, io_wdata,
				io_write, io_bit_set, io_bit_clear, io_bit_sel);
		end else if (sel_input) begin
			toggle_bits = gpc_strobe(io_wdata, io_write,
				io_bit_set, io_bit_sel);
		end else if (sel_flag) begin
			flag_clear_bits = gpc_strobe(io_wdata, io_write,
				io_bit_set, io_bit_sel);
		end else if (sel_mcu) begin
			next_mcu = gpc_merge(next_mcu, io_wdata,
				io_write, io_bit_set, io_bit_clear, io_bit_sel);
		end else if (sel_ctrl) begin
			next_ctrl = gpc_merge(next_ctrl, io_wdata,
				io_write, io_bit_set, io_bit_clear, io_bit_sel);
		end else if (sel_mask0) begin
			next_mask0 = gpc_merge(next_mask0, io_wdata,
				io_write, io_bit_set, io_bit_clear, io_bit_sel);
		end else if (sel_mask1) begin
			next_mask1 = gpc_merge(next_mask1, io_wdata,
				io_write, io_bit_set, io_bit_clear, io_bit_sel);
		end else if (sel_mask2) begin
			next_mask2 = gpc_merge(next_mask2, io_wdata,
				io_write, io_bit_set, io_bit_clear, io_bit_sel);
		end
		// toggle through the input location
		// Independent of direction, zeros leave data alone
		next_data = next_data ^ toggle_bits;
	end

	// ----------------------------------------
	// Register storage
	// ----------------------------------------

	// Port and control registers
	always @(posedge clk) begin
		if (reset) begin
			// pins leave reset as plain inputs
			port_direction_reg     <= `GPC_RST_BYTE;
			port_output_data_reg   <= `GPC_RST_BYTE;
			pin_change_mask_group0 <= `GPC_RST_BYTE;
			pin_change_mask_group1 <= `GPC_RST_MASK1;
			pin_change_mask_group2 <= `GPC_RST_BYTE;
			pin_change_control_reg <= `GPC_RST_CTRL;
			global_pullup_disable  <= `GPC_ZERO_BIT;
		end else if (any_access) begin
			port_direction_reg     <= next_direction;
			port_output_data_reg   <= next_data;
			pin_change_mask_group0 <= next_mask0;
			pin_change_mask_group1 <= next_mask1[6:0];
			pin_change_mask_group2 <= next_mask2;
			pin_change_control_reg <= next_ctrl[2:0];
			global_pullup_disable  <= next_mcu[`GPC_MCU_PUD];
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------

	// Driver and pull-up state per pin
	always @(posedge clk) begin
		if (reset) begin
			drive_en <= `GPC_RST_BYTE;
			pull_en  <= `GPC_RST_BYTE;
			pin_out  <= `GPC_RST_BYTE;
		end else begin
			drive_en <= next_direction;
			pin_out  <= next_data;
			// pull-up only on inputs with data one
			pull_en  <= ~next_direction & next_data &
				{8{~next_mcu[`GPC_MCU_PUD]}};
		end
	end

	// reset tri-states the pins
	// Gated by reset itself so no clock edge is needed
	assign pin_oe     = drive_en & {8{~reset}};
	assign pin_pullup = pull_en & {8{~reset}};

	// ----------------------------------------
	// Pin change detection
	// ----------------------------------------

	always @(posedge clk) begin
		if (reset) begin
			port_prev   <= `GPC_RST_BYTE;
			group1_prev <= `GPC_RST_MASK1;
			group2_prev <= `GPC_RST_BYTE;
		end else begin
			port_prev   <= port_input_pins_reg;
			group1_prev <= group1_pins;
			group2_prev <= group2_pins;
		end
	end

	// Masked and enabled changes of each group
	always @* begin
		change_group0 = pin_change_control_reg[`GPC_CTRL_EN0] &
			(|((port_input_pins_reg ^ port_prev) &
			pin_change_mask_group0));
		change_group1 = pin_change_control_reg[`GPC_CTRL_EN1] &
			(|((group1_pins ^ group1_prev) & pin_change_mask_group1));
		change_group2 = pin_change_control_reg[`GPC_CTRL_EN2] &
			(|((group2_pins ^ group2_prev) & pin_change_mask_group2));
		// clear by service or by a written one
		next_flag = pin_change_flag_group0;
		if (irq_ack_group0 | flag_clear_bits[`GPC_FLAG_PCF0]) begin
			next_flag = 1'b0;
		end
		// set on a masked change
		// Set after the clear so a same-cycle event is kept
		if (change_group0) begin
			next_flag = 1'b1;
		end
	end

	// Flag, request lines and interrupt
	always @(posedge clk) begin
		if (reset) begin
			pin_change_flag_group0 <= `GPC_ZERO_BIT;
			pc_req_group1          <= `GPC_ZERO_BIT;
			pc_req_group2          <= `GPC_ZERO_BIT;
			irq_group0             <= `GPC_ZERO_BIT;
		end else begin
			pin_change_flag_group0 <= next_flag;
			// One-cycle requests for the flag owners of groups 1, 2
			pc_req_group1          <= change_group1;
			pc_req_group2          <= change_group2;
			// request needs global, enable and flag
			irq_group0             <= next_flag & global_int_enable &
				next_ctrl[`GPC_CTRL_EN0];
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------

	// Read mux; unmapped addresses return zero
	always @* begin
		next_rdata = 8'h00;
		if (sel_input) begin
			// value shows half to one and a half cycles after the pin settles
			next_rdata = port_input_pins_reg;
		end else if (sel_dir) begin
			next_rdata = port_direction_reg;
		end else if (sel_data) begin
			next_rdata = port_output_data_reg;
		end else if (sel_flag) begin
			next_rdata = {7'h00, pin_change_flag_group0};
		end else if (sel_mcu) begin
			next_rdata = {3'h0, global_pullup_disable, 4'h0};
		end else if (sel_ctrl) begin
			next_rdata = {5'h00, pin_change_control_reg};
		end else if (sel_mask0) begin
			next_rdata = pin_change_mask_group0;
		end else if (sel_mask1) begin
			next_rdata = {1'b0, pin_change_mask_group1};
		end else if (sel_mask2) begin
			next_rdata = pin_change_mask_group2;
		end
	end

	// Read data is held until the next read
	always @(posedge clk) begin
		if (reset) begin
			io_rdata <= `GPC_RST_BYTE;
		end else if (io_read) begin
			io_rdata <= next_rdata;
		end
	end

	// no cross-pin coupling
	// Every pin is driven by its own bits only, so a pin handed to
	// another function elsewhere leaves its neighbours untouched.

endmodule

// [dv/gpc_pins_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Board side of the port pins
// ----------------------------------------
module gpc_pins_model (
	// Clock
	input  wire       clk,
	// Drive from the port
	input  wire [7:0] pin_out,
	input  wire [7:0] pin_oe,
	input  wire [7:0] pin_pullup,
	// Board drivers
	input  wire [7:0] ext_val,
	input  wire [7:0] ext_en,
	// Resolved level
	output wire [7:0] pin_in
);
	reg  [7:0] last = 8'h00;
	wire [7:0] driven;
	// A pin is held by the port, the board or the pull-up
	assign driven = pin_oe | ext_en | pin_pullup;
	// Floating pins show the inverse of the last held level, so a stale
	// value cannot pass for a real drive; it does not ring every cycle
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & pin_pullup) | (~driven & ~last);
	// Last level seen while something held the pin
	always @(posedge clk) begin
		last <= (driven & pin_in) | (~driven & last);
	end
endmodule

// [dv/gpc_port_asserts.sv]
`timescale 1ns/100ps
`include "gpc_map.vh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module gpc_port_asserts (
	// Clock and reset
	input wire       clk,
	input wire       reset,
	// Register access
	input wire [7:0] io_addr,
	input wire [7:0] io_wdata,
	input wire       io_write,
	input wire       io_read,
	input wire       io_bit_set,
	input wire       io_bit_clear,
	input wire [2:0] io_bit_sel,
	input wire [7:0] io_rdata,
	// Interrupt and pins
	input wire       global_int_enable,
	input wire       irq_ack_group0,
	input wire       irq_group0,
	input wire [7:0] pin_out,
	input wire [7:0] pin_oe,
	input wire [7:0] pin_pullup
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Read request at one location
	sequence s_rd(a);
		io_read && io_addr == a;
	endsequence
	a_reset_tristate: assert property (disable iff (1'b0)
		reset |-> pin_oe == 8'h00 && pin_pullup == 8'h00)
		else $error("pins active in reset");
	a_pullup_input: assert property (
		(pin_pullup & (pin_oe | ~pin_out)) == 8'h00)
		else $error("pull-up on a driven or low pin");
	a_irq_needs_gie: assert property (
		!$past(global_int_enable) |-> !irq_group0)
		else $error("request without global enable");
	a_irq_fall_cause: assert property (
		$fell(irq_group0) |-> $past(irq_ack_group0) || $past(io_write)
		|| !$past(global_int_enable) || $past(io_bit_set)
		|| $past(io_bit_clear))
		else $error("request dropped without cause");
	a_read_dir: assert property (
		s_rd(`GPC_ADDR_DIR) |=> io_rdata == $past(pin_oe))
		else $error("direction readback wrong");
	a_read_data: assert property (
		s_rd(`GPC_ADDR_DATA) |=> io_rdata == $past(pin_out))
		else $error("data readback wrong");
	a_mask1_bit7: assert property (
		s_rd(`GPC_ADDR_MASK1) |=> !io_rdata[7])
		else $error("group-1 mask bit 7 read as one");
	a_input_toggle: assert property (
		io_write && io_addr == `GPC_ADDR_INPUT
		|=> pin_out == ($past(pin_out) ^ $past(io_wdata)))
		else $error("input write did not toggle data");
	a_bit_set_dir: assert property (
		io_bit_set && io_addr == `GPC_ADDR_DIR
		|=> pin_oe == ($past(pin_oe) | (8'h01 << $past(io_bit_sel))))
		else $error("bit set touched other pins");
	a_bit_clr_data: assert property (
		io_bit_clear && io_addr == `GPC_ADDR_DATA
		|=> pin_out == ($past(pin_out) & ~(8'h01 << $past(io_bit_sel))))
		else $error("bit clear touched other pins");
endmodule

bind gpc_port gpc_port_asserts i_gpc_port_asserts (.clk(clk), .reset(reset),
	.io_addr(io_addr), .io_wdata(io_wdata), .io_write(io_write),
	.io_read(io_read), .io_bit_set(io_bit_set), .io_bit_clear(io_bit_clear),
	.io_bit_sel(io_bit_sel), .io_rdata(io_rdata),
	.global_int_enable(global_int_enable), .irq_ack_group0(irq_ack_group0),
	.irq_group0(irq_group0), .pin_out(pin_out), .pin_oe(pin_oe),
	.pin_pullup(pin_pullup));

// [dv/gpc_port_tb_top.sv]
`timescale 1ns/100ps
`include "gpc_map.vh"
module gpc_port_tb_top;
	// Stimulus and observed signals
	logic       clk, reset, io_write, io_read, io_bit_set, io_bit_clear;
	logic       global_int_enable, irq_ack_group0, rd_d, seen;
	logic [7:0] io_addr, io_wdata, group2_pins, ext_val, ext_en, d, t;
	logic [6:0] group1_pins;
	logic [2:0] io_bit_sel;
	wire  [7:0] io_rdata, pin_in, pin_out, pin_oe, pin_pullup;
	wire        irq_group0, pc_req_group1, pc_req_group2;
	logic [7:0] exp_q[$];
	integer     seed, num_errors, n_checks;

	gpc_port i_gpc_port (.clk(clk), .reset(reset), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_write(io_write), .io_read(io_read),
		.io_bit_set(io_bit_set), .io_bit_clear(io_bit_clear),
		.io_bit_sel(io_bit_sel), .io_rdata(io_rdata),
		.global_int_enable(global_int_enable),
		.irq_ack_group0(irq_ack_group0), .irq_group0(irq_group0),
		.group1_pins(group1_pins), .group2_pins(group2_pins),
		.pc_req_group1(pc_req_group1), .pc_req_group2(pc_req_group2),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup));
	gpc_pins_model i_gpc_pins_model (.clk(clk), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pullup(pin_pullup), .ext_val(ext_val),
		.ext_en(ext_en), .pin_in(pin_in));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Compare and count
	task chk(input string nm, input logic [7:0] sv, ev);
		n_checks = n_checks + 1;
		if (sv !== ev) begin
			num_errors = num_errors + 1;
			$display("[ERR] %s expected %h seen %h", nm, ev, sv);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Bus cycles: strobe held one edge, then a gap edge
	task wr(input logic [7:0] a, v);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= v;
		io_write <= 1'b1;
		@(posedge clk);
		io_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a, e);
		exp_q.push_back(e);
		@(posedge clk);
		io_addr <= a;
		io_read <= 1'b1;
		@(posedge clk);
		io_read <= 1'b0;
	endtask
	task bop(input logic s, input logic [7:0] a, input logic [2:0] b);
		@(posedge clk);
		io_addr <= a;
		io_bit_sel <= b;
		io_bit_set <= s;
		io_bit_clear <= ~s;
		@(posedge clk);
		io_bit_set <= 1'b0;
		io_bit_clear <= 1'b0;
	endtask
	// Bounded look for an event output
	task wait_ev(input integer w, input logic e);
		seen = 1'b0;
		repeat (8) begin
			@(posedge clk);
			#1;
			if ((w == 0) ? irq_group0 === 1'b1 : (w == 1) ?
				pc_req_group1 === 1'b1 : pc_req_group2 === 1'b1)
				seen = 1'b1;
		end
		chk("event", {7'h00, seen}, {7'h00, e});
		if (e && !seen)
			complete_run;
	endtask
	// Read results against oldest note
	always @(posedge clk) begin
		if (rd_d)
			chk("rdata", io_rdata, exp_q.pop_front());
		rd_d <= io_read;
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors = num_errors + 1;
		complete_run;
	end
	// Main sequence
	initial begin
		{seed, num_errors, n_checks} = {32'd18, 32'd0, 32'd0};
		{reset, rd_d, io_write, io_read, io_bit_set} = 5'b10000;
		{io_bit_clear, global_int_enable, irq_ack_group0} = 3'b000;
		{io_addr, io_wdata, io_bit_sel, group1_pins} = 26'h0;
		{group2_pins, ext_val, ext_en} = 24'h0000ff;
		repeat (6) @(posedge clk);
		#1;
		chk("oe_rst", pin_oe, 8'h00);
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		rd(`GPC_ADDR_DIR, 8'h00);
		rd(`GPC_ADDR_DATA, 8'h00);
		rd(`GPC_ADDR_MASK2, 8'h00);
		$display("reset values done");
		repeat (4) begin
			d = $random(seed);
			wr(`GPC_ADDR_MASK2, d);
			rd(`GPC_ADDR_MASK2, d);
			wr(`GPC_ADDR_MASK1, d);
			rd(`GPC_ADDR_MASK1, {1'b0, d[6:0]});
			wr(`GPC_ADDR_MASK0, d);
			rd(`GPC_ADDR_MASK0, d);
		end
		wr(8'h40, 8'hff);
		rd(8'h40, 8'h00);
		$display("registers done");
		@(posedge clk);
		ext_en <= 8'h00;
		wr(`GPC_ADDR_DATA, 8'hff); // via pull-up state
		#1;
		chk("pullup", pin_pullup, 8'hff);
		rd(`GPC_ADDR_INPUT, 8'hff);
		wr(`GPC_ADDR_MCU, 8'h10);
		#1;
		chk("pud", pin_pullup, 8'h00);
		wr(`GPC_ADDR_MCU, 8'h00);
		wr(`GPC_ADDR_DIR, 8'hff);
		#1;
		chk("oe", pin_oe, 8'hff);
		d = $random(seed);
		wr(`GPC_ADDR_DATA, d);
		#1;
		chk("out", pin_out, d);
		rd(`GPC_ADDR_INPUT, d);
		t = $random(seed);
		wr(`GPC_ADDR_INPUT, t);
		rd(`GPC_ADDR_DATA, d ^ t);
		bop(1'b0, `GPC_ADDR_DIR, 3'd5);
		rd(`GPC_ADDR_DIR, 8'hdf);
		bop(1'b1, `GPC_ADDR_DIR, 3'd5);
		rd(`GPC_ADDR_DIR, 8'hff);
		bop(1'b0, `GPC_ADDR_DATA, 3'd2);
		rd(`GPC_ADDR_DATA, (d ^ t) & 8'hfb);
		$display("pin control done");
		@(posedge clk);
		ext_en <= 8'hff;
		ext_val <= 8'h00;
		wr(`GPC_ADDR_DIR, 8'h00); // via 00 or 11 only
		wr(`GPC_ADDR_MASK0, 8'h01);
		wr(`GPC_ADDR_CTRL, 8'h01);
		global_int_enable <= 1'b1;
		@(posedge clk);
		ext_val <= 8'h02;
		wait_ev(0, 1'b0);
		@(posedge clk);
		ext_val <= 8'h03;
		wait_ev(0, 1'b1);
		rd(`GPC_ADDR_FLAG, 8'h01);
		@(posedge clk);
		irq_ack_group0 <= 1'b1;
		@(posedge clk);
		irq_ack_group0 <= 1'b0;
		#1;
		chk("irq_ack", {7'h00, irq_group0}, 8'h00);
		@(posedge clk);
		ext_val <= 8'h00;
		wait_ev(0, 1'b1);
		wr(`GPC_ADDR_FLAG, 8'h01);
		#1;
		chk("irq_w1c", {7'h00, irq_group0}, 8'h00);
		@(posedge clk);
		global_int_enable <= 1'b0;
		ext_val <= 8'h01;
		wait_ev(0, 1'b0);
		rd(`GPC_ADDR_FLAG, 8'h01);
		$display("group 0 change done");
		wr(`GPC_ADDR_MASK2, 8'h80);
		wr(`GPC_ADDR_MASK1, 8'h40);
		wr(`GPC_ADDR_CTRL, 8'h07);
		group2_pins <= 8'h01;
		wait_ev(2, 1'b0);
		@(posedge clk);
		group2_pins <= 8'h81;
		wait_ev(2, 1'b1);
		@(posedge clk);
		group1_pins <= 7'h40;
		wait_ev(1, 1'b1);
		$display("group 1 and 2 done");
		repeat (2) @(posedge clk);
		complete_run;
	end
endmodule
